// >>> srq_eng_model.sv
/*
 srq_eng_model: behavioural measurement and zeroing engine beside the block.
 assumes start, halt and zeroing requests are one-cycle pulses on ref_clk_i.
*/
`timescale 1ns/1ns
module srq_eng_model (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// requests
	input  wire logic        start_i,
	input  wire logic        halt_i,
	input  wire logic        zero_go_i,
	// answers
	output logic             done_o,
	output logic [31:0]      data_o,
	output logic             zero_busy_o
);
	logic [7:0] mcnt;
	logic [7:0] zcnt;

	// a result lands 9 cycles after a start, zeroing runs 40 cycles
	always_ff @(posedge ref_clk_i) begin
		done_o <= mcnt == 8'h01;
		if (mcnt != 8'h00)
			mcnt <= mcnt - 8'h01;
		if (zcnt != 8'h00)
			zcnt <= zcnt - 8'h01;
		if (start_i)
			mcnt <= 8'h09;
		if (zero_go_i)
			zcnt <= 8'h28;
		if (mcnt == 8'h01)
			data_o <= data_o + 32'h0000_0001;
		// a halt drops work in flight, so no stale result follows it
		if (!rst_n_i || halt_i) begin
			mcnt <= 8'h00;
			zcnt <= 8'h00;
			done_o <= 1'b0;
		end
		if (!rst_n_i)
			data_o <= 32'hA500_0000;
	end

	assign zero_busy_o = zcnt != 8'h00;
endmodule // srq_eng_model

// >>> srq_pkg.sv
/*
 srq_pkg: constants, command codes, states and carriers of the status byte
 and common-command block.
 assumes one 100 MHz clock and a link parser that hands over decoded commands.
*/
// Overview of operation
// - mask write rounds argument to an integer 0..255, stored as mask bits 0..7
// - a set mask bit lets the matching status bit feed the summary
// - mask query answers the mask as an unsigned integer
// - summary bit 6 is OR of status bits, except bit 6, ANDed with mask
// - status query gives bits 0..5 and 7 directly, summary in bit 6
// - bit 1 shows a device status condition; bit 0 unused, reads zero
// - bit 3 shows a questionable status condition
// - bit 4 is one while a response waits in the output buffer
// - bit 5 shows an enabled standard event; bit 7 shows operation status
// - bus trigger with source other than bus logs -211 and is ignored
// - bus trigger outside the wait-for-trigger state logs -211 and is discarded
// - self-test runs about 25 s then answers 0 on pass, 1 on fail
// - wait command holds off commands until pending work ends or device clear
// - device clear halts work, empties output buffer, resets the parser
// - save-state accepts slot numbers 1 to 10 only
// - read acts as initiate plus fetch; measure acts as configure plus read
// - free-run mode measures repeatedly; fetch answers from the result buffer
// - operation-complete query answers 1 once zeroing has finished
package srq_pkg;

	//----------------------------------------
	// timing and field constants
	//----------------------------------------
	localparam longint unsigned CLK_HZ     = 100_000_000;
	localparam longint unsigned TST_TIME_S = 25;
	localparam longint unsigned TST_CYC    = TST_TIME_S * CLK_HZ;
	localparam int              ARG_FRAC   = 8;            // argument fraction bits
	localparam logic [31:0]     ARG_HALF   = 32'h0000_0080;
	localparam logic [7:0]      MASK_RST   = 8'h00;
	localparam logic [7:0]      MASK_MAX   = 8'hFF;
	localparam int              STB_DEV    = 1;
	localparam int              STB_EQ     = 2;
	localparam int              STB_QUES   = 3;
	localparam int              STB_MAV    = 4;
	localparam int              STB_ESB    = 5;
	localparam int              STB_RQS    = 6;
	localparam int              STB_OPER   = 7;
	localparam logic [7:0]      RQS_EXCL   = 8'hBF;        // every bit but the summary
	localparam logic [15:0]     ERR_TRIG   = 16'hFF2D;     // -211, trigger ignored
	localparam logic [3:0]      SLOT_MIN   = 4'h1;
	localparam logic [3:0]      SLOT_MAX   = 4'hA;
	localparam logic [31:0]     ANS_PASS   = 32'h0000_0000;
	localparam logic [31:0]     ANS_FAIL   = 32'h0000_0001;
	localparam logic [31:0]     ANS_OPC    = 32'h0000_0001;

	//----------------------------------------
	// enumerations
	//----------------------------------------
	typedef enum logic [3:0] {
		C_MASK_WR = 4'b0000, C_MASK_RD = 4'b0001, C_STB_RD  = 4'b0010,
		C_TRG     = 4'b0011, C_TST     = 4'b0100, C_WAI     = 4'b0101,
		C_OPC_Q   = 4'b0110, C_SAVE    = 4'b0111, C_CFG     = 4'b1000,
		C_START   = 4'b1001, C_FETCH   = 4'b1010, C_READ    = 4'b1011,
		C_MEASURE = 4'b1100, C_CONT_ON = 4'b1101, C_CONT_OFF = 4'b1110
	} srq_cmd_t;

	typedef enum logic [1:0] {
		TS_IMM = 2'b00, TS_BUS = 2'b01, TS_HOLD = 2'b10, TS_EXT = 2'b11
	} srq_trig_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_WAIT = 3'b001, S_TEST = 3'b010,
		S_OPC = 3'b011, S_FETCH = 3'b100
	} srq_state_t;

	//----------------------------------------
	// carriers
	//----------------------------------------
	typedef struct packed {
		srq_cmd_t    code;
		logic [31:0] arg;     // signed, ARG_FRAC fraction bits
	} srq_req_t;

	typedef struct packed {
		logic oper;  // operation status summary
		logic esb;   // enabled standard event summary
		logic ques;  // questionable status summary
		logic eq;    // error/event queue not empty
		logic dev;   // device-specific condition
	} srq_status_t;

	typedef struct packed {
		srq_state_t  st;
		logic [7:0]  mask;
		logic        cont_mode;
		logic        wait_trig;
		logic        measuring;
		logic        have_result;
		logic        resp_valid;
		logic [31:0] resp_data;
		logic        err_valid;
		logic [15:0] err_code;
		logic        measure_result_query_start;
		logic        cfg;
		logic        clear;
		logic        save;
		logic [3:0]  slot;
		logic [31:0] tcnt;
	} srq_regs_t;

	localparam srq_regs_t REGS_RST = '0;  // idle, mask MASK_RST, nothing pending

endpackage

// >>> srq_round.sv
/*
 srq_round: turns a fixed-point command argument into an 8-bit mask value.
 assumes the argument is two's complement with ARG_FRAC fraction bits.
*/
`timescale 1ns/1ns
module srq_round
	import srq_pkg::*;
(
	// argument in
	input  wire logic [31:0] arg_i,
	// rounded value out
	output logic      [7:0]  val_o
);

	logic [31:0] sum;
	logic [23:0] whole;

	//----------------------------------------
	// round half up, then clamp to 0..255
	//----------------------------------------
	always_comb begin
		sum   = arg_i + ARG_HALF;
		whole = sum[31:ARG_FRAC];
		// sign taken before rounding: a huge positive argument may carry into bit 31
		if (arg_i[31]) begin
			val_o = MASK_RST;  // negative rounds to zero
		end else if (|whole[23:8]) begin
			val_o = MASK_MAX;  // saturate instead of wrapping
		end else begin
			val_o = whole[7:0];
		end
	end

endmodule // srq_round

// >>> srq_stb.sv
/*
 srq_stb: assembles the status byte and its request summary bit.
 assumes all status levels come from logic on the same clock.
*/
`timescale 1ns/1ns
module srq_stb
	import srq_pkg::*;
(
	// status sources
	input  wire srq_status_t stat_i,
	input  wire logic        mav_i,
	input  wire logic [7:0]  mask_i,
	// assembled byte
	output logic      [7:0]  stb_o
);

	logic [7:0] raw;
	logic       request_summary_bit;

	//----------------------------------------
	// pure combinational, so reading never disturbs a bit
	//----------------------------------------
	always_comb begin
		raw           = 8'h00;            // bit 0 unused
		raw[STB_DEV]  = stat_i.dev;
		raw[STB_EQ]   = stat_i.eq;
		raw[STB_QUES] = stat_i.ques;
		raw[STB_MAV]  = mav_i;
		raw[STB_ESB]  = stat_i.esb;
		raw[STB_OPER] = stat_i.oper;
		request_summary_bit = |(raw & mask_i & RQS_EXCL);
		stb_o         = raw;
		stb_o[STB_RQS] = request_summary_bit;
	end

endmodule // srq_stb

// >>> srq_top.sv
/*
 srq_top: status byte, service request mask and common commands of the
 measurement instrument.
 assumes a link parser that presents one decoded command at a time, a
 measurement engine and zeroing engine on the same clock, and a host that
 takes each answer before sending the next command.
*/
`timescale 1ns/1ns
module srq_top
	import srq_pkg::*;
#(
	parameter logic [31:0] TST_CYCLES = 32'(TST_CYC),
	parameter logic [15:0] ERR_SLOT   = 16'hFF22
)(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// decoded command stream
	input  wire logic        cmd_valid_i,
	input  wire srq_req_t    cmd_i,
	output logic             cmd_ready_o,
	// answers to queries
	output logic             resp_valid_o,
	output logic [31:0]      resp_data_o,
	input  wire logic        resp_ready_i,
	// device clear from the link
	input  wire logic        dcl_i,
	output logic             parser_rst_o,
	output logic             halt_o,
	// status sources
	input  wire srq_status_t stat_i,
	output logic [7:0]       stb_o,
	// error/event log
	output logic             err_valid_o,
	output logic [15:0]      err_code_o,
	// measurement engine
	input  wire srq_trig_t   trig_src_i,
	output logic             measure_result_query_start_o,
	output logic             cfg_o,
	input  wire logic        measure_result_query_done_i,
	input  wire logic [31:0] measure_result_query_data_i,
	input  wire logic        zero_busy_i,
	input  wire logic        test_pass_i,
	// state store
	output logic             save_o,
	output logic [3:0]       save_slot_o
);

	srq_regs_t   r;
	srq_regs_t   next_r;
	logic [7:0]  mask_rnd;
	logic        take;
	logic        busy;
	logic        do_start;
	logic        slot_ok;
	logic [31:0] hi_arg;

	//----------------------------------------
	// helpers
	//----------------------------------------
	srq_round u_round (
		.arg_i (cmd_i.arg),
		.val_o (mask_rnd)
	);

	srq_stb u_stb (
		.stat_i (stat_i),
		.mav_i  (r.resp_valid),
		.mask_i (r.mask),
		.stb_o  (stb_o)
	);

	// one answer slot; commands stall while it is full
	assign cmd_ready_o = (r.st == S_IDLE) && !r.resp_valid;
	assign take        = cmd_valid_i && cmd_ready_o;
	// free-run never finishes, so only single shots and zeroing count as pending
	assign busy        = zero_busy_i || (r.measuring && !r.cont_mode);
	assign hi_arg      = cmd_i.arg >> ARG_FRAC;
	assign slot_ok     = (hi_arg >= 32'(SLOT_MIN)) && (hi_arg <= 32'(SLOT_MAX));

	//----------------------------------------
	// next-state logic
	//----------------------------------------
	always_comb begin
		next_r            = r;
		do_start          = 1'b0;
		next_r.measure_result_query_start = 1'b0;
		next_r.cfg        = 1'b0;
		next_r.clear      = 1'b0;
		next_r.save       = 1'b0;
		next_r.err_valid  = 1'b0;

		// engine results land in the buffer
		if (measure_result_query_done_i) begin
			next_r.measuring   = 1'b0;
			next_r.have_result = 1'b1;
		end

		// free-run relaunches as soon as the engine is idle
		if (r.cont_mode && !r.measuring && !r.measure_result_query_start) begin
			next_r.measure_result_query_start = 1'b1;
			next_r.measuring  = 1'b1;
		end

		// host drains the answer
		if (r.resp_valid && resp_ready_i) begin
			next_r.resp_valid = 1'b0;
		end

		unique case (r.st)
			S_IDLE: begin
				if (take) begin
					case (cmd_i.code)
						C_MASK_WR: begin
							next_r.mask = mask_rnd;
						end
						C_MASK_RD: begin
							next_r.resp_valid = 1'b1;
							next_r.resp_data  = {24'h00_0000, r.mask};
						end
						C_STB_RD: begin
							// no bit is cleared by this read
							next_r.resp_valid = 1'b1;
							next_r.resp_data  = {24'h00_0000, stb_o};
						end
						C_TRG: begin
							if (trig_src_i != TS_BUS || !r.wait_trig) begin
								next_r.err_valid = 1'b1;
								next_r.err_code  = ERR_TRIG;
							end else begin
								next_r.wait_trig  = 1'b0;
								next_r.measure_result_query_start = 1'b1;
								next_r.measuring  = 1'b1;
							end
						end
						C_TST: begin
							next_r.st   = S_TEST;
							next_r.tcnt = 32'h0000_0000;
						end
						C_WAI: begin
							next_r.st = S_WAIT;
						end
						C_OPC_Q: begin
							next_r.st = S_OPC;
						end
						C_SAVE: begin
							if (slot_ok) begin
								next_r.save = 1'b1;
								next_r.slot = hi_arg[3:0];
							end else begin
								next_r.err_valid = 1'b1;
								next_r.err_code  = ERR_SLOT;
							end
						end
						C_CFG: begin
							next_r.cfg         = 1'b1;
							next_r.have_result = 1'b0;
						end
						C_START: begin
							do_start = 1'b1;
						end
						C_FETCH: begin
							next_r.st = S_FETCH;
						end
						C_READ: begin
							do_start  = 1'b1;
							next_r.st = S_FETCH;
						end
						C_MEASURE: begin
							// configure forces an immediate source, so start now
							next_r.cfg         = 1'b1;
							next_r.have_result = 1'b0;
							next_r.measure_result_query_start  = 1'b1;
							next_r.measuring   = 1'b1;
							next_r.st          = S_FETCH;
						end
						C_CONT_ON: begin
							next_r.cont_mode = 1'b1;
						end
						C_CONT_OFF: begin
							next_r.cont_mode = 1'b0;
						end
						default: begin
						end
					endcase
				end
			end
			S_WAIT: begin
				// commands stay stalled until nothing is pending
				if (!busy) begin
					next_r.st = S_IDLE;
				end
			end
			S_TEST: begin
				next_r.tcnt = r.tcnt + 32'h0000_0001;
				if (r.tcnt >= TST_CYCLES - 32'h0000_0001) begin
					next_r.st         = S_IDLE;
					next_r.resp_valid = 1'b1;
					next_r.resp_data  = test_pass_i ? ANS_PASS : ANS_FAIL;
				end
			end
			S_OPC: begin
				if (!zero_busy_i) begin
					next_r.st         = S_IDLE;
					next_r.resp_valid = 1'b1;
					next_r.resp_data  = ANS_OPC;
				end
			end
			S_FETCH: begin
				// single shot waits for the result the host started first
				if (r.cont_mode || r.have_result) begin
					next_r.st         = S_IDLE;
					next_r.resp_valid = 1'b1;
					next_r.resp_data  = measure_result_query_data_i;
				end
			end
			default: begin
				next_r.st = S_IDLE;
			end
		endcase

		// initiate: start at once on immediate source, else arm
		if (do_start) begin
			next_r.have_result = 1'b0;
			if (trig_src_i == TS_IMM) begin
				next_r.measure_result_query_start = 1'b1;
				next_r.measuring  = 1'b1;
			end else begin
				next_r.wait_trig = 1'b1;
			end
		end

		// device clear overrides the state, answer, trigger arm, measuring, start and save above
		if (dcl_i) begin
			next_r.st          = S_IDLE;
			next_r.resp_valid  = 1'b0;
			next_r.clear       = 1'b1;
			next_r.wait_trig   = 1'b0;
			next_r.measuring   = 1'b0;
			next_r.measure_result_query_start  = 1'b0;
			next_r.save        = 1'b0;
		end
	end

	//----------------------------------------
	// state register
	//----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			r <= REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	//----------------------------------------
	// outputs, all straight from flops
	//----------------------------------------
	assign resp_valid_o = r.resp_valid;
	assign resp_data_o  = r.resp_data;
	assign parser_rst_o = r.clear;
	assign halt_o       = r.clear;
	assign err_valid_o  = r.err_valid;
	assign err_code_o   = r.err_code;
	assign measure_result_query_start_o = r.measure_result_query_start;
	assign cfg_o        = r.cfg;
	assign save_o       = r.save;
	assign save_slot_o  = r.slot;

	//----------------------------------------
	// checks
	//----------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_mask_wr;
		take && cmd_i.code == C_MASK_WR && !dcl_i |=> r.mask == $past(mask_rnd);
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("mask not stored");

	property p_mask_rd;
		take && cmd_i.code == C_MASK_RD && !dcl_i
			|=> resp_valid_o && resp_data_o == {24'h00_0000, $past(r.mask)};
	endproperty
	a_mask_rd: assert property (p_mask_rd) else $error("mask query wrong");

	property p_rqs;
		stb_o[STB_RQS] == |({stat_i.oper, stat_i.esb, r.resp_valid, stat_i.ques,
			stat_i.eq, stat_i.dev} & {r.mask[7], r.mask[5:1]});
	endproperty
	a_rqs: assert property (p_rqs) else $error("summary bit wrong");

	property p_mav;
		stb_o[STB_MAV] == resp_valid_o && stb_o[0] == 1'b0;
	endproperty
	a_mav: assert property (p_mav) else $error("message bit wrong");

	property p_trg;
		take && cmd_i.code == C_TRG && !dcl_i && (trig_src_i != TS_BUS || !r.wait_trig)
			|=> err_valid_o && err_code_o == ERR_TRIG && !measure_result_query_start_o;
	endproperty
	a_trg: assert property (p_trg) else $error("bad trigger not logged");

	property p_dcl;
		dcl_i |=> !resp_valid_o && parser_rst_o && halt_o && cmd_ready_o;
	endproperty
	a_dcl: assert property (p_dcl) else $error("device clear incomplete");

	property p_wai;
		r.st == S_WAIT && busy && !dcl_i |=> !cmd_ready_o;
	endproperty
	a_wai: assert property (p_wai) else $error("wait released early");

	property p_save;
		take && cmd_i.code == C_SAVE && !slot_ok && !dcl_i
			|=> !save_o && err_valid_o && err_code_o == ERR_SLOT;
	endproperty
	a_save: assert property (p_save) else $error("bad slot accepted");

	property p_opc;
		r.st == S_OPC && !zero_busy_i && !dcl_i
			|=> resp_valid_o && resp_data_o == ANS_OPC;
	endproperty
	a_opc: assert property (p_opc) else $error("completion answer wrong");

	property p_tst;
		take && cmd_i.code == C_TST && !dcl_i |=> !resp_valid_o && !cmd_ready_o;
	endproperty
	a_tst: assert property (p_tst) else $error("self-test answered at once");

	property p_fetch;
		take && cmd_i.code == C_FETCH && r.cont_mode && !dcl_i ##1 !dcl_i
			|=> resp_valid_o && resp_data_o == $past(measure_result_query_data_i);
	endproperty
	a_fetch: assert property (p_fetch) else $error("free-run fetch late");

	property p_rst;
		!rst_n_i |=> r.mask == MASK_RST && !resp_valid_o;
	endproperty
	a_rst: assert property (disable iff (1'b0) p_rst) else $error("mask reset");

endmodule // srq_top

// >>> tb_srq_top.sv
/*
 tb_srq_top: self-checking bench for the status byte and common commands.
 assumes the engine model on the far side and a short self-test count.
*/
`timescale 1ns/1ns
module tb_srq_top;
	import srq_pkg::*;
	localparam logic [31:0] TCY   = 32'h0000_0014;
	localparam logic [15:0] ESLOT = 16'hFF22;
	localparam logic [31:0] BASE  = 32'hA500_0000;
	logic ref_clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, resp_valid_o, resp_ready_i;
	logic dcl_i, parser_rst_o, halt_o, err_valid_o, measure_result_query_start_o, cfg_o, measure_result_query_done_i;
	logic zero_busy_i, test_pass_i, save_o, zero_go;
	logic        [31:0] resp_data_o, measure_result_query_data_i, got;
	logic        [15:0] err_code_o, last_err;
	logic        [7:0]  stb_o, stb_pend;
	logic        [3:0]  save_slot_o, last_slot;
	srq_req_t           cmd_i;
	srq_status_t        stat_i;
	srq_trig_t          trig_src_i;
	int error_cnt = 0, cmp_count = 0, cyc = 0, lat, i, e0, s0, c0, v0, ok;
	int n_err = 0, n_start = 0, n_cfg = 0, n_save = 0, n_prst = 0, n_done = 0;
	logic [31:0] rarg [6] = '{32'h0000_0580, 32'h0000_057F, 32'hFFFF_FF00,
		32'h0001_2C00, 32'h0000_FF00, 32'h7FFF_FFC0};
	logic [7:0]  rexp [6] = '{8'h06, 8'h05, 8'h00, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0]  wt [5]   = '{8'h02, 8'h04, 8'h08, 8'h20, 8'h80};
	logic [3:0]  sl [4]   = '{4'h0, 4'h1, 4'hA, 4'hB};

	srq_top #(.TST_CYCLES(TCY), .ERR_SLOT(ESLOT)) srq_top_i (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
		.cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o),
		.resp_data_o(resp_data_o), .resp_ready_i(resp_ready_i), .dcl_i(dcl_i),
		.parser_rst_o(parser_rst_o), .halt_o(halt_o), .stat_i(stat_i), .stb_o(stb_o),
		.err_valid_o(err_valid_o), .err_code_o(err_code_o), .trig_src_i(trig_src_i),
		.measure_result_query_start_o(measure_result_query_start_o), .cfg_o(cfg_o), .measure_result_query_done_i(measure_result_query_done_i),
		.measure_result_query_data_i(measure_result_query_data_i), .zero_busy_i(zero_busy_i),
		.test_pass_i(test_pass_i), .save_o(save_o), .save_slot_o(save_slot_o));
	srq_eng_model srq_eng_model_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.start_i(measure_result_query_start_o), .halt_i(halt_o), .zero_go_i(zero_go),
		.done_o(measure_result_query_done_i), .data_o(measure_result_query_data_i), .zero_busy_o(zero_busy_i));

	//----------------------------------------
	// clock, pulse counters and hang guard
	//----------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// pulses last one cycle, so each is counted at the edge that ends it
	always @(posedge ref_clk_i) begin
		cyc++;
		n_start += int'(measure_result_query_start_o === 1'b1);
		n_cfg += int'(cfg_o === 1'b1);
		n_prst += int'(parser_rst_o === 1'b1);
		n_done += int'(measure_result_query_done_i === 1'b1);
		if (err_valid_o === 1'b1) begin
			n_err++;
			last_err = err_code_o;
		end
		if (save_o === 1'b1) begin
			n_save++;
			last_slot = save_slot_o;
		end
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	//----------------------------------------
	// access tasks
	//----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// command is held until an edge where ready was high
	task automatic send(input srq_cmd_t c, input logic [31:0] a);
		int n;
		n = 0;
		@(negedge ref_clk_i);
		cmd_valid_i = 1'b1;
		cmd_i.code = c;
		cmd_i.arg = a;
		while (cmd_ready_o !== 1'b1 && n < 400) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n >= 400) begin
			error_cnt++;  // command never taken
			report_and_stop();
		end
		@(negedge ref_clk_i);
		cmd_valid_i = 1'b0;
	endtask
	task automatic wait_resp();
		lat = 0;
		while (resp_valid_o !== 1'b1 && lat < 400) begin
			@(negedge ref_clk_i);
			lat++;
		end
		if (lat >= 400) begin
			error_cnt++;  // answer never came
			report_and_stop();
		end
		got = resp_data_o;
		stb_pend = stb_o;
	endtask
	task automatic take();
		resp_ready_i = 1'b1;
		@(negedge ref_clk_i);
		resp_ready_i = 1'b0;
	endtask
	task automatic query(input srq_cmd_t c, input logic [31:0] a);
		send(c, a);
		wait_resp();
		take();
	endtask
	task automatic pulse_dcl();
		@(negedge ref_clk_i);
		dcl_i = 1'b1;
		@(negedge ref_clk_i);
		dcl_i = 1'b0;
	endtask
	task automatic pulse_zero();
		@(negedge ref_clk_i);
		zero_go = 1'b1;
		@(negedge ref_clk_i);
		zero_go = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial begin
		{rst_n_i, cmd_valid_i, resp_ready_i, dcl_i, zero_go, test_pass_i} = '0;
		cmd_i = '0;
		stat_i = '0;
		trig_src_i = TS_IMM;
		repeat (12) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		query(C_MASK_RD, 0);
		chk("mask reset", 0, got);
		// rounding: half up, negative to zero, large to the top
		for (i = 0; i < 6; i++) begin
			send(C_MASK_WR, rarg[i]);
			query(C_MASK_RD, 0);
			chk("mask", rexp[i], got);
		end
		// each source alone, enabled and then excluded by the mask
		for (i = 0; i < 5; i++) begin
			stat_i = srq_status_t'(5'h01 << i);
			send(C_MASK_WR, {16'h0000, wt[i], 8'h00});
			chk("stb port", wt[i] | 8'h40, stb_o);
			query(C_STB_RD, 0);
			chk("stb own", wt[i] | 8'h40, got);
			send(C_MASK_WR, {16'h0000, ~wt[i], 8'h00});
			query(C_STB_RD, 0);
			chk("stb other", wt[i], got);
		end
		stat_i = '1;
		send(C_MASK_WR, 32'h0000_1000);
		query(C_STB_RD, 0);
		chk("stb all", 8'hAE, got);
		chk("stb pending", 8'hFE, stb_pend);
		chk("stb taken", 8'hAE, stb_o);
		stat_i = '0;
		// bus trigger refused unless armed with the bus source
		e0 = n_err;
		s0 = n_start;
		send(C_TRG, 0);
		trig_src_i = TS_BUS;
		send(C_TRG, 0);
		idle(2);
		chk("trg idle", e0 + 2, n_err);
		chk("trg code", ERR_TRIG, last_err);
		send(C_START, 0);
		send(C_TRG, 0);
		idle(2);
		chk("trg start", s0 + 1, n_start);
		chk("trg no err", e0 + 2, n_err);
		idle(12);
		trig_src_i = TS_EXT;
		send(C_START, 0);
		send(C_TRG, 0);
		idle(2);
		chk("trg ext", e0 + 3, n_err);
		chk("trg ext start", s0 + 1, n_start);
		pulse_dcl();
		trig_src_i = TS_IMM;
		// single-shot and free-run result paths, then self-test and completion query
		send(C_CONT_OFF, 0);
		s0 = n_start;
		c0 = n_cfg;
		query(C_READ, 0);
		chk("read", BASE + n_done, got);
		query(C_MEASURE, 0);
		chk("measure", BASE + n_done, got);
		chk("measure cfg", c0 + 1, n_cfg);
		send(C_CFG, 0);
		send(C_START, 0);
		query(C_FETCH, 0);
		chk("fetch", BASE + n_done, got);
		chk("starts", s0 + 3, n_start);
		send(C_CONT_ON, 0);
		s0 = n_start;
		idle(40);
		query(C_FETCH, 0);
		chk("free run", 1, n_start >= s0 + 2);
		chk("fetch buf", BASE[31:16], got[31:16]);
		send(C_CONT_OFF, 0);
		idle(12);
		for (i = 0; i < 2; i++) begin
			test_pass_i = (i == 0);
			query(C_TST, 0);
			chk("test", i, got);
			chk("test time", 1, lat >= TCY);
		end
		pulse_zero();
		query(C_OPC_Q, 0);
		chk("opc", ANS_OPC, got);
		chk("opc wait", 1, lat >= 30);
		// wait holds off commands, device clear releases it
		pulse_zero();
		send(C_WAI, 0);
		idle(1);
		chk("wai hold", 0, cmd_ready_o);
		c0 = n_prst;
		pulse_dcl();
		chk("halt", 1, halt_o);
		idle(1);
		chk("wai end", 1, cmd_ready_o);
		chk("parser reset", c0 + 1, n_prst);
		send(C_STB_RD, 0);
		wait_resp();
		pulse_dcl();
		chk("dcl buffer", 0, resp_valid_o);
		chk("dcl mav", 0, stb_o[4]);
		for (i = 0; i < 4; i++) begin
			e0 = n_err;
			v0 = n_save;
			send(C_SAVE, {20'h00000, sl[i], 8'h00});
			idle(2);
			ok = (sl[i] >= SLOT_MIN) && (sl[i] <= SLOT_MAX);
			chk("save", v0 + ok, n_save);
			chk("save err", e0 + 1 - ok, n_err);
			chk("save id", ok ? 32'(sl[i]) : 32'(ESLOT),
				ok ? 32'(last_slot) : 32'(last_err));
		end
		report_and_stop();
	end
endmodule // tb_srq_top
